/* flash_host_cfg.svh */
// constants for the parallel flash host controller
`ifndef FLASH_HOST_CFG_SVH
`define FLASH_HOST_CFG_SVH
`define UNLOCK1_ADDR 18'h00555
`define UNLOCK1_DATA 8'haa
`define UNLOCK2_ADDR 18'h002aa
`define UNLOCK2_DATA 8'h55
`define CMD_SETUP 8'h80
`define CMD_SECTOR_ERASE 8'h30
`define CMD_PROGRAM 8'ha0
`define CMD_SUSPEND 8'hb0
`define CMD_RESUME 8'h30
`define CMD_RESET 8'hf0
`define BIT_DATA_POLL 7
`define BIT_TOGGLE_ONE 6
`define BIT_TIMEOUT 5
`define BIT_ERASE_WINDOW 3
`define BIT_TOGGLE_TWO 2
`define CLK_PERIOD_NS 5
`define WRITE_LOW_NS 40
`define WRITE_LOW_CYC ((`WRITE_LOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define READ_ACCESS_NS 120
`define READ_ACCESS_CYC ((`READ_ACCESS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define LOAD_WINDOW_MS 30
`define LOAD_WINDOW_CYC (`LOAD_WINDOW_MS * 1000000 / `CLK_PERIOD_NS)
`define REG_CTRL 32'h00
`define REG_ADDR 32'h04
`define REG_DATA 32'h08
`define REG_STATUS 32'h0c
`define REG_READ 32'h10
`define OP_NONE 3'h0
`define OP_PROGRAM 3'h1
`define OP_ERASE 3'h2
`define OP_ERASE_MORE 3'h3
`define OP_SUSPEND 3'h4
`define OP_RESUME 3'h5
`define OP_RESET 3'h6
`define OP_READ 3'h7
`endif

/* flash_host_pkg.sv */
// types for the parallel flash host controller
package flash_host_pkg;
	typedef struct packed {
		logic [17:0] addr;
		logic [7:0] data;
	} bus_word_t;
	typedef struct packed {
		logic chip_en_n;
		logic out_en_n;
		logic write_en_n;
	} strobe_t;
	typedef enum logic [6:0] {
		ST_IDLE = 7'h01,
		ST_WRITE = 7'h02,
		ST_GAP = 7'h04,
		ST_POLL_A = 7'h08,
		ST_POLL_B = 7'h10,
		ST_READ = 7'h20,
		ST_DONE = 7'h40
	} host_state_t;
endpackage

/* flash_bus_cycle.sv */
// one strobe cycle on the flash pins, write or read
`timescale 1ns/1ps
`include "flash_host_cfg.svh"
module flash_bus_cycle (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// request
	input wire logic start,
	input wire logic is_write,
	input wire flash_host_pkg::bus_word_t word,
	output logic busy,
	output logic done,
	output logic [7:0] rd_data_reg,
	// flash pins
	output logic [17:0] addr_pin,
	output logic [7:0] dq_out,
	output logic dq_oe_n,
	input wire logic [7:0] dq_in,
	output flash_host_pkg::strobe_t strobes
);
	logic [7:0] cnt_reg;
	logic wr_reg;
	logic act_reg;
	logic done_reg;
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			act_reg <= 1'b0;
			cnt_reg <= 8'h00;
			wr_reg <= 1'b0;
		end else if (start && !act_reg) begin
			act_reg <= 1'b1;
			wr_reg <= is_write;
			cnt_reg <= is_write ? 8'(`WRITE_LOW_CYC) : 8'(`READ_ACCESS_CYC);
		end else if (act_reg) begin
			if (cnt_reg == 8'h00)
				act_reg <= 1'b0;
			else
				cnt_reg <= cnt_reg - 8'h01;
		end
	end
	// address, data and strobes all change on the same start edge, data held past the strobe rise
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			addr_pin <= 18'h00000;
			dq_out <= 8'h00;
			dq_oe_n <= 1'b1;
			strobes <= '{1'b1, 1'b1, 1'b1};
		end else if (start && !act_reg) begin
			addr_pin <= word.addr;
			dq_out <= word.data;
			dq_oe_n <= !is_write;
			strobes <= '{1'b0, is_write, !is_write};
		end else if (act_reg && cnt_reg == 8'h00) begin
			strobes <= '{1'b1, 1'b1, 1'b1};
		end else if (done_reg) begin
			dq_oe_n <= 1'b1;
		end
	end
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst)
			rd_data_reg <= 8'h00;
		else if (act_reg && cnt_reg == 8'h00 && !wr_reg)
			rd_data_reg <= dq_in;
	end
	// done rises on the same edge as the release, the edge that also registers read data
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst)
			done_reg <= 1'b0;
		else
			done_reg <= act_reg && cnt_reg == 8'h00;
	end
	// busy covers the trailing cycle too, keeping strobes high between transfers
	assign busy = act_reg || done_reg;
	assign done = done_reg;
endmodule

/* flash_host_ctrl.sv */
// host controller that issues flash command sequences and polls status
//
// Decided for this implementation: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "flash_host_cfg.svh"
module flash_host_ctrl #(
	parameter int unsigned LOAD_WINDOW_CYC = `LOAD_WINDOW_CYC
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// axi4-lite write address and data
	input wire logic [31:0] s_awaddr,
	input wire logic s_awvalid,
	output logic s_awready,
	input wire logic [31:0] s_wdata,
	input wire logic [3:0] s_wstrb,
	input wire logic s_wvalid,
	output logic s_wready,
	// axi4-lite write response
	output logic [1:0] s_bresp,
	output logic s_bvalid,
	input wire logic s_bready,
	// axi4-lite read
	input wire logic [31:0] s_araddr,
	input wire logic s_arvalid,
	output logic s_arready,
	output logic [31:0] s_rdata,
	output logic [1:0] s_rresp,
	output logic s_rvalid,
	input wire logic s_rready,
	// flash pins
	output logic [17:0] flash_addr,
	output logic [7:0] flash_dq_out,
	output logic flash_dq_oe_n,
	input wire logic [7:0] flash_dq_in,
	output logic flash_ce_n,
	output logic flash_oe_n,
	output logic flash_we_n
);
	flash_host_pkg::host_state_t state_reg;
	flash_host_pkg::bus_word_t seq_word [0:5];
	flash_host_pkg::bus_word_t cur_word;
	flash_host_pkg::strobe_t strobes;
	logic [2:0] op_reg;
	logic [2:0] idx_reg;
	logic [2:0] len_reg;
	logic [17:0] addr_reg;
	logic [7:0] data_reg;
	logic [7:0] poll_a_reg, read_reg, cyc_rd;
	logic [31:0] win_cnt_reg;
	logic busy_reg, fail_reg, window_late_reg, aw_hold, w_hold;
	logic [31:0] aw_addr_reg;
	logic [31:0] w_data_reg;
	logic cyc_start, cyc_write, cyc_busy, cyc_done;
	logic toggling, wr_go;
	// third word carries the command; erase also uses words 3..5
	always_comb begin
		seq_word[0] = '{`UNLOCK1_ADDR, `UNLOCK1_DATA};
		seq_word[1] = '{`UNLOCK2_ADDR, `UNLOCK2_DATA};
		case (op_reg)
			`OP_PROGRAM: seq_word[2] = '{`UNLOCK1_ADDR, `CMD_PROGRAM};
			`OP_ERASE: seq_word[2] = '{`UNLOCK1_ADDR, `CMD_SETUP};
			`OP_SUSPEND: seq_word[2] = '{addr_reg, `CMD_SUSPEND};
			default: seq_word[2] = '{addr_reg, `CMD_RESET};
		endcase
		seq_word[3] = '{`UNLOCK1_ADDR, `UNLOCK1_DATA};
		seq_word[4] = '{`UNLOCK2_ADDR, `UNLOCK2_DATA};
		seq_word[5] = '{addr_reg, `CMD_SECTOR_ERASE};
	end
	// single-write ops and the program target come from the register pair
	always_comb begin
		cur_word = seq_word[idx_reg];
		if (state_reg != flash_host_pkg::ST_WRITE)
			cur_word = '{addr_reg, 8'h00};
		else if (op_reg == `OP_ERASE_MORE || op_reg == `OP_RESUME)
			cur_word = '{addr_reg, `CMD_SECTOR_ERASE};
		else if (op_reg == `OP_SUSPEND)
			cur_word = '{addr_reg, `CMD_SUSPEND};
		else if (op_reg == `OP_RESET)
			cur_word = '{addr_reg, `CMD_RESET};
		else if (op_reg == `OP_PROGRAM && idx_reg == 3'h3)
			cur_word = '{addr_reg, data_reg};
	end
	flash_bus_cycle u_cycle (
		.core_clk(core_clk),
		.rst(rst),
		.start(cyc_start),
		.is_write(cyc_write),
		.word(cur_word),
		.busy(cyc_busy),
		.done(cyc_done),
		.rd_data_reg(cyc_rd),
		.addr_pin(flash_addr),
		.dq_out(flash_dq_out),
		.dq_oe_n(flash_dq_oe_n),
		.dq_in(flash_dq_in),
		.strobes(strobes)
	);
	assign flash_ce_n = strobes.chip_en_n;
	assign flash_oe_n = strobes.out_en_n;
	assign flash_we_n = strobes.write_en_n;
	assign cyc_write = state_reg == flash_host_pkg::ST_WRITE;
	assign cyc_start = !cyc_busy && (state_reg == flash_host_pkg::ST_WRITE ||
		state_reg == flash_host_pkg::ST_POLL_A || state_reg == flash_host_pkg::ST_POLL_B ||
		state_reg == flash_host_pkg::ST_READ);
	assign toggling = (poll_a_reg[`BIT_TOGGLE_ONE] != cyc_rd[`BIT_TOGGLE_ONE]);
	// axi4-lite write path: address and data in either order
	assign s_awready = !aw_hold && !s_bvalid;
	assign s_wready = !w_hold && !s_bvalid;
	assign s_bresp = 2'h0;
	assign wr_go = aw_hold && w_hold && !s_bvalid;
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			aw_hold <= 1'b0;
			w_hold <= 1'b0;
			aw_addr_reg <= 32'h0;
			w_data_reg <= 32'h0;
			s_bvalid <= 1'b0;
		end else begin
			if (s_awvalid && s_awready) begin
				aw_hold <= 1'b1;
				aw_addr_reg <= s_awaddr;
			end
			if (s_wvalid && s_wready) begin
				w_hold <= 1'b1;
				w_data_reg <= s_wdata;
			end
			if (wr_go) begin
				aw_hold <= 1'b0;
				w_hold <= 1'b0;
				s_bvalid <= 1'b1;
			end else if (s_bvalid && s_bready)
				s_bvalid <= 1'b0;
		end
	end
	// address and data registers; strobes are ignored for these byte fields
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			addr_reg <= 18'h0;
			data_reg <= 8'h0;
		end else if (wr_go && aw_addr_reg[7:0] == 8'(`REG_ADDR))
			addr_reg <= w_data_reg[17:0];
		else if (wr_go && aw_addr_reg[7:0] == 8'(`REG_DATA))
			data_reg <= w_data_reg[7:0];
	end
	// sequencer
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state_reg <= flash_host_pkg::ST_IDLE;
			op_reg <= `OP_NONE;
			idx_reg <= 3'h0;
			len_reg <= 3'h0;
			poll_a_reg <= 8'h0;
			read_reg <= 8'h0;
			fail_reg <= 1'b0;
		end else begin
			case (state_reg)
				flash_host_pkg::ST_IDLE: begin
					if (wr_go && aw_addr_reg[7:0] == 8'(`REG_CTRL) && w_data_reg[2:0] != `OP_NONE) begin
						op_reg <= w_data_reg[2:0];
						idx_reg <= 3'h0;
						fail_reg <= 1'b0;
						case (w_data_reg[2:0])
							`OP_PROGRAM: len_reg <= 3'h4;
							`OP_ERASE: len_reg <= 3'h6;
							`OP_READ: len_reg <= 3'h0;
							default: len_reg <= 3'h1;
						endcase
						state_reg <= w_data_reg[2:0] == `OP_READ ? flash_host_pkg::ST_READ
							: flash_host_pkg::ST_WRITE;
					end
				end
				flash_host_pkg::ST_WRITE: begin
					if (cyc_done) begin
						idx_reg <= idx_reg + 3'h1;
						state_reg <= flash_host_pkg::ST_GAP;
					end
				end
				flash_host_pkg::ST_GAP: begin
					if (idx_reg != len_reg)
						state_reg <= flash_host_pkg::ST_WRITE;
					else if (op_reg == `OP_PROGRAM)
						state_reg <= flash_host_pkg::ST_POLL_A;
					else
						state_reg <= flash_host_pkg::ST_DONE;
				end
				flash_host_pkg::ST_POLL_A: begin
					if (cyc_done) begin
						poll_a_reg <= cyc_rd;
						state_reg <= flash_host_pkg::ST_POLL_B;
					end
				end
				flash_host_pkg::ST_POLL_B: begin
					if (cyc_done) begin
						read_reg <= cyc_rd;
						if (!toggling)
							state_reg <= flash_host_pkg::ST_DONE;
						else if (poll_a_reg[`BIT_TIMEOUT] && cyc_rd[`BIT_TIMEOUT]) begin
							// second stable-check failed after timeout: abort
							fail_reg <= 1'b1;
							op_reg <= `OP_RESET;
							idx_reg <= 3'h0;
							len_reg <= 3'h1;
							state_reg <= flash_host_pkg::ST_WRITE;
						end else begin
							poll_a_reg <= cyc_rd;
							state_reg <= flash_host_pkg::ST_POLL_B;
						end
					end
				end
				flash_host_pkg::ST_READ: begin
					if (cyc_done) begin
						read_reg <= cyc_rd;
						state_reg <= flash_host_pkg::ST_DONE;
					end
				end
				flash_host_pkg::ST_DONE: state_reg <= flash_host_pkg::ST_IDLE;
				default: state_reg <= flash_host_pkg::ST_IDLE;
			endcase
		end
	end
	assign busy_reg = state_reg != flash_host_pkg::ST_IDLE;
	// load window tracking: count since last erase write rise
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			win_cnt_reg <= 32'h0;
			window_late_reg <= 1'b1;
		end else if (state_reg == flash_host_pkg::ST_GAP &&
			(op_reg == `OP_ERASE || op_reg == `OP_ERASE_MORE) && idx_reg == len_reg) begin
			win_cnt_reg <= LOAD_WINDOW_CYC;
			window_late_reg <= 1'b0;
		end else if (win_cnt_reg != 32'h0)
			win_cnt_reg <= win_cnt_reg - 32'h1;
		else
			window_late_reg <= 1'b1;
	end
	// axi4-lite read path
	assign s_arready = !s_rvalid;
	assign s_rresp = 2'h0;
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			s_rvalid <= 1'b0;
			s_rdata <= 32'h0;
		end else if (s_arvalid && s_arready) begin
			s_rvalid <= 1'b1;
			case (s_araddr[7:0])
				8'(`REG_ADDR): s_rdata <= {14'h0, addr_reg};
				8'(`REG_DATA): s_rdata <= {24'h0, data_reg};
				8'(`REG_STATUS): s_rdata <= {29'h0, window_late_reg, fail_reg, busy_reg};
				8'(`REG_READ): s_rdata <= {24'h0, read_reg};
				default: s_rdata <= 32'h0;
			endcase
		end else if (s_rvalid && s_rready)
			s_rvalid <= 1'b0;
	end
	a_write_strobe_width: assert property (@(posedge core_clk) disable iff (rst)
		$fell(flash_we_n) |-> !flash_we_n [*8]) else $error("write strobe too short");
	a_write_oe_high: assert property (@(posedge core_clk) disable iff (rst)
		!flash_we_n |-> flash_oe_n && !flash_dq_oe_n) else $error("write without data drive");
	a_erase_last_cmd: assert property (@(posedge core_clk) disable iff (rst)
		$fell(flash_we_n) && op_reg == `OP_ERASE && idx_reg == 3'h5 |-> flash_dq_out == `CMD_SECTOR_ERASE
		&& flash_addr == addr_reg) else $error("erase sixth write wrong");
	a_prog_cmd: assert property (@(posedge core_clk) disable iff (rst)
		$fell(flash_we_n) && op_reg == `OP_PROGRAM && idx_reg == 3'h2 |-> flash_dq_out == `CMD_PROGRAM)
		else $error("program command wrong");
	a_prog_target: assert property (@(posedge core_clk) disable iff (rst)
		$fell(flash_we_n) && op_reg == `OP_PROGRAM && idx_reg == 3'h3 |-> flash_dq_out == data_reg)
		else $error("program target wrong");
	a_poll_twice: assert property (@(posedge core_clk) disable iff (rst)
		state_reg == flash_host_pkg::ST_POLL_A && cyc_done |=> state_reg == flash_host_pkg::ST_POLL_B)
		else $error("single status read");
	a_timeout_reset: assert property (@(posedge core_clk) disable iff (rst)
		state_reg == flash_host_pkg::ST_POLL_B && cyc_done && toggling && poll_a_reg[`BIT_TIMEOUT]
		&& cyc_rd[`BIT_TIMEOUT] |=> op_reg == `OP_RESET && fail_reg) else $error("no reset after timeout");
	a_unlock_first: assert property (@(posedge core_clk) disable iff (rst)
		$fell(flash_we_n) && idx_reg == 3'h0 && (op_reg == `OP_ERASE || op_reg == `OP_PROGRAM)
		|-> flash_dq_out == `UNLOCK1_DATA) else $error("unlock wrong");
	c_erase: cover property (@(posedge core_clk) op_reg == `OP_ERASE && state_reg == flash_host_pkg::ST_DONE);
	c_program: cover property (@(posedge core_clk) op_reg == `OP_PROGRAM && state_reg == flash_host_pkg::ST_DONE);
	c_abort: cover property (@(posedge core_clk) fail_reg && state_reg == flash_host_pkg::ST_DONE);
endmodule

/* flash_dev_model.sv */
// behavioural flash device answering the host controller
`timescale 1ns/1ps
`include "flash_host_cfg.svh"
module flash_dev_model #(
	parameter int PROG_NS = 2000,
	parameter int ERASE_NS = 20000,
	parameter int WIN_NS = 1000,
	parameter int PROT_NS = 2000
) (
	// flash pins
	input wire logic [17:0] flash_addr,
	input wire logic [7:0] flash_dq_out,
	input wire logic flash_dq_oe_n,
	output logic [7:0] flash_dq_in,
	input wire logic flash_ce_n,
	input wire logic flash_oe_n,
	input wire logic flash_we_n
);
	localparam int RD = 0, PG = 1, SPG = 2, WIN = 3, ER = 4, SUS = 5, STK = 6, PRW = 7;
	// 16k sectors, a simplified map
	logic [7:0] mem [logic [17:0]];
	logic [15:0] sel = '0, prot = '0;
	logic stuck_next = 1'h0, t1 = 1'h0, t2 = 1'h0;
	int mode = 0, step = 0, n_resets = 0, bus_faults = 0;
	time dl, left;
	logic [17:0] wa, pa;
	logic [7:0] wd, pd, v, dout = '0;
	wire wr_n = flash_ce_n | flash_we_n | ~flash_oe_n;
	wire rd_n = flash_ce_n | flash_oe_n;
	// released bus shows the inverse of the last byte, not a stale copy
	assign flash_dq_in = rd_n ? ~dout : dout;
	function automatic logic [7:0] arr(input logic [17:0] a);
		return mem.exists(a) ? mem[a] : 8'hff;
	endfunction
	function automatic logic unl(input bit two);
		if (two)
			return wa == `UNLOCK2_ADDR && wd == `UNLOCK2_DATA;
		return wa == `UNLOCK1_ADDR && wd == `UNLOCK1_DATA;
	endfunction
	always @(negedge wr_n) wa = flash_addr;
	always @(posedge wr_n) begin
		wd = flash_dq_out;
		bus_faults += flash_dq_oe_n;
		if (mode == STK && wd == `CMD_RESET) begin
			mode = RD;
			n_resets++;
		end else if (mode == ER && wd == `CMD_SUSPEND) begin
			left = dl - $time;
			mode = SUS;
		end else if (mode == WIN) begin
			dl = $time + WIN_NS;
			if (wd == `CMD_SECTOR_ERASE)
				sel[wa[17:14]] = 1'h1;
			else if (wd == `CMD_SUSPEND) begin
				left = ERASE_NS;
				mode = SUS;
			end else begin
				sel = '0;
				mode = RD;
			end
		end else if (mode == RD || mode == SUS) begin
			if (step == 0 && unl(0))
				step = 1;
			else if ((step == 1 || step == 5) && unl(1))
				step = step + 1;
			else if (step == 2 && wd == `CMD_PROGRAM)
				step = 3;
			else if (step == 3) begin
				step = 0;
				pa = wa;
				pd = wd;
				dl = $time + (prot[wa[17:14]] ? PROT_NS : PROG_NS);
				mode = prot[wa[17:14]] ? PRW : stuck_next ? STK : mode == SUS ? SPG : PG;
			end else if (step == 2 && wd == `CMD_SETUP && mode == RD)
				step = 4;
			else if (step == 4 && unl(0))
				step = 5;
			else if (step == 6 && wd == `CMD_SECTOR_ERASE) begin
				step = 0;
				sel[wa[17:14]] = 1'h1;
				dl = $time + WIN_NS;
				mode = WIN;
			end else if (step == 0 && mode == SUS && wd == `CMD_RESUME) begin
				dl = $time + left;
				mode = ER;
			end else begin
				step = 0;
				n_resets += (wd == `CMD_RESET);
			end
		end
	end
	always #5 begin
		if (mode inside {PG, SPG, PRW, WIN, ER} && $time >= dl) begin
			if (mode == WIN) begin
				mode = (sel & ~prot) == 0 ? PRW : ER;
				dl = $time + (mode == PRW ? PROT_NS : ERASE_NS);
			end else if (mode == ER) begin
				foreach (mem[a])
					if (sel[a[17:14]] && !prot[a[17:14]])
						mem[a] = 8'hff;
				sel = '0;
				mode = RD;
			end else begin
				if (mode == PRW)
					sel = '0;
				else
					mem[pa] = arr(pa) & pd;
				mode = mode == SPG ? SUS : RD;
			end
		end
	end
	always @(negedge rd_n) begin
		v = arr(flash_addr);
		if (mode != RD && mode != SUS)
			t1 = ~t1;
		if (sel[flash_addr[17:14]])
			t2 = ~t2;
		case (mode)
			PG, SPG, STK: dout = {~pd[7], t1, mode == STK, 5'h00};
			WIN, ER: dout = {1'h0, t1, 2'h0, mode == ER, t2, 2'h0};
			PRW: dout = {v[7], t1, 1'b0, v[4:0]};
			SUS: dout = sel[flash_addr[17:14]] ? {2'h2, 3'h0, t2, 2'h0} : v;
			default: dout = v;
		endcase
	end
endmodule

/* flash_erase_program_state_machine_tb_top.sv */
// self-checking bench for the flash host controller
`timescale 1ns/1ps
`include "flash_host_cfg.svh"
module flash_erase_program_state_machine_tb_top;
	logic core_clk = 1'h0, rst = 1'h1;
	logic [31:0] s_awaddr = '0, s_wdata = '0, s_araddr = '0, s_rdata, rd;
	logic s_awvalid = 1'h0, s_wvalid = 1'h0, s_bready = 1'h0, s_arvalid = 1'h0, s_rready = 1'h0;
	logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
	logic [1:0] s_bresp, s_rresp;
	logic [17:0] flash_addr;
	logic [7:0] flash_dq_out, flash_dq_in;
	logic flash_dq_oe_n, flash_ce_n, flash_oe_n, flash_we_n;
	int mismatches = 0, n_tests = 0, base;
	always #2.5 core_clk = ~core_clk;
	flash_host_ctrl #(.LOAD_WINDOW_CYC(200)) DUT (.core_clk(core_clk), .rst(rst), .s_awaddr(s_awaddr),
		.s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(4'hf), .s_wvalid(s_wvalid),
		.s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr),
		.s_arvalid(s_arvalid), .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid),
		.s_rready(s_rready), .flash_addr(flash_addr), .flash_dq_out(flash_dq_out), .flash_dq_oe_n(flash_dq_oe_n),
		.flash_dq_in(flash_dq_in), .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n));
	flash_dev_model dev (.flash_addr(flash_addr), .flash_dq_out(flash_dq_out), .flash_dq_oe_n(flash_dq_oe_n),
		.flash_dq_in(flash_dq_in), .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n));
	task automatic close_out();
		if (mismatches == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			$display("ERROR %s expected %h seen %h", what, exp, got);
			mismatches++;
		end
	endtask
	task automatic axi_write(input logic [31:0] a, input logic [31:0] d);
		logic done;
		done = 1'h0;
		@(posedge core_clk);
		s_awaddr <= a;
		s_wdata <= d;
		s_awvalid <= 1'h1;
		s_wvalid <= 1'h1;
		s_bready <= 1'h1;
		while (!done) begin
			@(posedge core_clk);
			if (s_awready)
				s_awvalid <= 1'h0;
			if (s_wready)
				s_wvalid <= 1'h0;
			if (s_bvalid) begin
				done = 1'h1;
				s_bready <= 1'h0;
				check("bresp", 32'h0, {30'h0, s_bresp});
			end
		end
	endtask
	task automatic axi_read(input logic [31:0] a, output logic [31:0] d);
		logic done;
		done = 1'h0;
		@(posedge core_clk);
		s_araddr <= a;
		s_arvalid <= 1'h1;
		s_rready <= 1'h1;
		while (!done) begin
			@(posedge core_clk);
			if (s_arready)
				s_arvalid <= 1'h0;
			if (s_rvalid) begin
				done = 1'h1;
				d = s_rdata;
				check("rresp", 32'h0, {30'h0, s_rresp});
				s_rready <= 1'h0;
			end
		end
	endtask
	// leaves the final status word in rd
	task automatic run_op(input logic [2:0] code);
		axi_write(`REG_CTRL, {29'h0, code});
		rd = 32'h1;
		while (rd[0] !== 1'h0)
			axi_read(`REG_STATUS, rd);
	endtask
	task automatic addr_op(input logic [17:0] a, input logic [2:0] code);
		axi_write(`REG_ADDR, {14'h0, a});
		run_op(code);
	endtask
	task automatic prog(input logic [17:0] a, input logic [7:0] d);
		axi_write(`REG_DATA, {24'h0, d});
		addr_op(a, `OP_PROGRAM);
	endtask
	task automatic rd_arr(input logic [17:0] a);
		addr_op(a, `OP_READ);
		axi_read(`REG_READ, rd);
	endtask
	initial begin
		#400000;
		mismatches++;
		close_out();
	end
	initial begin
		repeat (4) @(posedge core_clk);
		rst <= 1'h0;
		axi_read(`REG_STATUS, rd);
		check("status", 32'h0, rd & 32'h3);
		axi_read(32'h40, rd);
		check("unmapped", 32'h0, rd);
		prog(18'h08010, 8'h5a);
		check("fail", 32'h0, rd & 32'h2);
		check("array", 32'h5a, {24'h0, dev.arr(18'h08010)});
		check("dq drive", 32'h0, dev.bus_faults);
		rd_arr(18'h08010);
		check("read", 32'h5a, rd & 32'hff);
		run_op(`OP_SUSPEND);
		check("mode", dev.RD, dev.mode);
		// device stuck: host must abort with reset
		base = dev.n_resets;
		dev.stuck_next = 1'h1;
		prog(18'h01300, 8'h00);
		dev.stuck_next = 1'h0;
		check("fail", 32'h2, rd & 32'h2);
		check("resets", base + 1, dev.n_resets);
		dev.prot[5] = 1'h1;
		prog(18'h14010, 8'hc3);
		check("array", 32'hff, {24'h0, dev.arr(18'h14010)});
		check("fail", 32'h0, rd & 32'h2);
		addr_op(18'h18000, `OP_ERASE);
		check("select", 32'h40, {16'h0, dev.sel});
		run_op(`OP_RESET);
		check("select", 32'h0, {16'h0, dev.sel});
		// two sectors, suspend, program elsewhere, resume
		addr_op(18'h08000, `OP_ERASE);
		addr_op(18'h0c000, `OP_ERASE_MORE);
		check("select", 32'h0c, {16'h0, dev.sel});
		run_op(`OP_SUSPEND);
		check("mode", dev.SUS, dev.mode);
		rd_arr(18'h08010);
		check("suspended", 32'h80, rd & 32'h80);
		prog(18'h00100, 8'h3c);
		check("array", 32'h3c, {24'h0, dev.arr(18'h00100)});
		check("mode", dev.SUS, dev.mode);
		run_op(`OP_RESUME);
		check("mode", dev.ER, dev.mode);
		while (dev.mode != dev.RD)
			@(posedge core_clk);
		rd_arr(18'h08010);
		check("erased", 32'hff, rd & 32'hff);
		addr_op(18'h1c000, `OP_ERASE);
		repeat (300) @(posedge core_clk);
		axi_read(`REG_STATUS, rd);
		check("window", 32'h4, rd & 32'h4);
		check("mode", dev.ER, dev.mode);
		close_out();
	end
endmodule
